/* srxe_bit_rx.sv */
// serial byte receiver: start bit, 8 data bits lsb first, optional parity, one stop bit
// assumes rx_pin is asynchronous to core_clk and idles high
`timescale 1ns/1ps
`include "srxe_defines.svh"
module srxe_bit_rx
  import srxe_pkg::*;
#(
  parameter int BIT_CYCLES = `SRXE_BIT_CYCLES
) (
  input  wire logic         core_clk,
  input  wire logic         sys_rst,
  input  wire logic         rx_pin,
  input  wire logic         par_en,
  input  wire logic         par_odd,
  output logic              evt_valid,
  output srxe_rx_evt_s      evt
);
  typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_PAR, RX_STOP} srxe_rx_st_e;

  logic [2:0]   sync_r;
  logic         lvl_r;
  logic         lvl_nxt;
  srxe_rx_st_e  st_r;
  srxe_rx_st_e  st_nxt;
  logic [15:0]  cnt_r;
  logic [15:0]  cnt_nxt;
  logic [2:0]   bit_r;
  logic [2:0]   bit_nxt;
  logic [7:0]   sh_r;
  logic [7:0]   sh_nxt;
  logic         perr_r;
  logic         perr_nxt;
  logic         ev_v_nxt;
  srxe_rx_evt_s ev_nxt;
  logic         tick;

  localparam logic [15:0] FULL = 16'(BIT_CYCLES - 1);
  localparam logic [15:0] HALF = 16'(BIT_CYCLES / 2 - 1);

  assign tick = (cnt_r == 16'h0000);

  always_comb begin
    // only the second and third stages decide a level change
    lvl_nxt  = (sync_r[1] == sync_r[2]) ? sync_r[2] : lvl_r;
    st_nxt   = st_r;
    cnt_nxt  = tick ? FULL : cnt_r - 16'h0001;
    bit_nxt  = bit_r;
    sh_nxt   = sh_r;
    perr_nxt = perr_r;
    ev_v_nxt = 1'b0;
    ev_nxt   = evt;
    case (st_r)
      RX_IDLE: begin
        cnt_nxt = HALF;
        if (!lvl_r) begin
          st_nxt = RX_START;
        end
      end
      RX_START: begin
        if (tick) begin
          // a glitch shorter than half a bit is not a start
          st_nxt  = lvl_r ? RX_IDLE : RX_DATA;
          bit_nxt = 3'h0;
        end
      end
      RX_DATA: begin
        if (tick) begin
          sh_nxt  = {lvl_r, sh_r[7:1]};
          bit_nxt = bit_r + 3'h1;
          if (bit_r == 3'h7) begin
            st_nxt = par_en ? RX_PAR : RX_STOP;
          end
        end
      end
      RX_PAR: begin
        if (tick) begin
          perr_nxt = (^sh_r ^ lvl_r) != par_odd;
          st_nxt   = RX_STOP;
        end
      end
      RX_STOP: begin
        if (tick) begin
          ev_v_nxt       = 1'b1;
          ev_nxt.data    = sh_r;
          ev_nxt.par_err = par_en & perr_r;
          ev_nxt.frm_err = !lvl_r;
          perr_nxt       = 1'b0;
          st_nxt         = RX_IDLE;
        end
      end
      default: st_nxt = RX_IDLE;
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      sync_r    <= 3'h7;
      lvl_r     <= 1'b1;
      st_r      <= RX_IDLE;
      cnt_r     <= 16'h0000;
      bit_r     <= 3'h0;
      sh_r      <= 8'h00;
      perr_r    <= 1'b0;
      evt_valid <= 1'b0;
      evt       <= '0;
    end else begin
      sync_r    <= {sync_r[1:0], rx_pin};
      lvl_r     <= lvl_nxt;
      st_r      <= st_nxt;
      cnt_r     <= cnt_nxt;
      bit_r     <= bit_nxt;
      sh_r      <= sh_nxt;
      perr_r    <= perr_nxt;
      evt_valid <= ev_v_nxt;
      evt       <= ev_nxt;
    end
  end
endmodule

/* srxe_defines.svh */
// offsets, field positions, reset values and timing counts of the receive error block
// assumes inclusion by the package, the design modules and the bench
`ifndef SRXE_DEFINES_SVH
`define SRXE_DEFINES_SVH

// register indices; byte address is four times the index
`define SRXE_IDX_CTRL        10'h100
`define SRXE_IDX_STATUS      10'h101
`define SRXE_IDX_ERR_CLEAR   10'h102
`define SRXE_IDX_RX_DATA     10'h103
`define SRXE_IDX_IRQ_STATUS  10'h104
`define SRXE_IDX_IRQ_MASK    10'h105

// error-clear word bit positions (values 32, 64, 128)
`define SRXE_CLR_SUM_BIT     5
`define SRXE_CLR_PROTO_BIT   6
`define SRXE_CLR_OVR_BIT     7

// control register fields
`define SRXE_CTRL_MODE_LSB   0
`define SRXE_CTRL_SUM_EN     2
`define SRXE_CTRL_RESP_EN    3
`define SRXE_CTRL_PAR_EN     4
`define SRXE_CTRL_PAR_ODD    5
`define SRXE_CTRL_RESET      8'h00

// interrupt bit positions
`define SRXE_IRQ_SUM         0
`define SRXE_IRQ_PROTO       1
`define SRXE_IRQ_OVR         2
`define SRXE_IRQ_RX_DATA     3
`define SRXE_IRQ_FRAME_OK    4
`define SRXE_IRQ_W           5

// frame control bytes
`define SRXE_HEAD_BYTE       8'h05
`define SRXE_TERM_BYTE       8'h0D
`define SRXE_ACK_BYTE        8'h06
`define SRXE_NAK_BYTE        8'h15

// timing
`define SRXE_CLK_HZ          10000000
`define SRXE_BAUD            9600
`define SRXE_BIT_CYCLES      (`SRXE_CLK_HZ / `SRXE_BAUD)
`define SRXE_MAX_FRAME       64

`endif

/* srxe_err_ctrl.sv */
// receive error handling of the second serial interface, with avalon-mm register slave
// assumes one 10 MHz clock, synchronous reset, rx_pin asynchronous, response bytes sent elsewhere
//
// Overview of operation
// - writing 32 to error-clear word ERROR_INDICATOR_CLEAR clears the sum-check/parity indicator
// - writing 64 to error-clear word ERROR_INDICATOR_CLEAR clears the protocol error indicator
// - writing 128 to error-clear word ERROR_INDICATOR_CLEAR clears the overrun/framing indicator
// - dedicated mode: error after frame head discards data or answers error end
// - dedicated and bidirectional: error before frame head silently discards data
// - no-protocol mode: drop only the erroneous byte, keep all others; a good byte arriving while the held byte is unread is lost as overrun
// - bidirectional mode: error after frame head answers with error-end response
// - indicators stay lit until host clears them; host must issue the clear
//
// Register access over Avalon-MM is this design's own decision.
`timescale 1ns/1ps
`include "srxe_defines.svh"
module srxe_err_ctrl
  import srxe_pkg::*;
#(
  parameter int BIT_CYCLES = `SRXE_BIT_CYCLES,
  parameter int MAX_FRAME  = `SRXE_MAX_FRAME
) (
  input  wire logic        core_clk,
  input  wire logic        sys_rst,
  input  wire logic [11:0] avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  input  wire logic        rx_pin,
  output logic             resp_valid,
  output logic      [7:0]  resp_data,
  input  wire logic        resp_ready,
  output logic             sum_error_indicator,
  output logic             protocol_error_indicator,
  output logic             serial_overrun_indicator,
  output logic             irq
);
  typedef enum logic [1:0] {FR_IDLE, FR_BODY} srxe_fr_st_e;

  // receiver
  logic         rx_valid;
  srxe_rx_evt_s rx_evt;
  logic         rx_bad;

  // bus
  logic         ack_r;
  logic         ack_nxt;
  logic [31:0]  rdata_nxt;
  logic [9:0]   idx;
  logic         aligned;
  logic         wr_go;
  logic         rd_go;
  logic [31:0]  rd_mux;
  logic         pop_arm_r;
  logic         pop_arm_nxt;
  logic         rd_pop;

  // registers
  srxe_ctrl_s   ctrl_r;
  srxe_ctrl_s   ctrl_nxt;
  logic [2:0]   ind_r;
  logic [2:0]   ind_nxt;
  logic [2:0]   ind_set;
  logic [2:0]   ind_clr;
  logic [`SRXE_IRQ_W-1:0] irq_st_r;
  logic [`SRXE_IRQ_W-1:0] irq_st_nxt;
  logic [`SRXE_IRQ_W-1:0] irq_mask_r;
  logic [`SRXE_IRQ_W-1:0] irq_mask_nxt;
  logic [`SRXE_IRQ_W-1:0] irq_ev;

  // received byte holding register for no-protocol mode
  logic [7:0]   rxd_r;
  logic [7:0]   rxd_nxt;
  logic         rxd_full_r;
  logic         rxd_full_nxt;

  // frame tracking
  srxe_fr_st_e  fr_r;
  srxe_fr_st_e  fr_nxt;
  logic [7:0]   sum_r;
  logic [7:0]   sum_nxt;
  logic [7:0]   prev_r;
  logic [7:0]   prev_nxt;
  logic [7:0]   len_r;
  logic [7:0]   len_nxt;
  logic         frame_ok;
  logic         sum_fail;
  logic         proto_fail;
  logic         overrun;
  logic         send_nak;
  logic         send_ack;

  // response
  logic         resp_valid_nxt;
  logic [7:0]   resp_data_nxt;

  localparam logic [7:0] MAX_LEN = 8'(MAX_FRAME);

  srxe_bit_rx #(
    .BIT_CYCLES (BIT_CYCLES)
  ) u_rx (
    .core_clk  (core_clk),
    .sys_rst   (sys_rst),
    .rx_pin    (rx_pin),
    .par_en    (ctrl_r.par_en),
    .par_odd   (ctrl_r.par_odd),
    .evt_valid (rx_valid),
    .evt       (rx_evt)
  );

  assign rx_bad = rx_evt.par_err | rx_evt.frm_err;

  // bus slave: one wait cycle, then the answer; write and pop act on the answering edge
  assign idx             = avs_address[11:2];
  assign aligned         = (avs_address[1:0] == 2'h0);
  assign avs_waitrequest = (avs_read | avs_write) & ~ack_r;
  assign wr_go           = avs_write & ack_r & aligned & avs_byteenable[0];
  assign rd_go           = avs_read & ack_r & aligned;

  always_comb begin
    rd_mux = 32'h0000_0000;
    if (aligned) begin
      case (idx)
        `SRXE_IDX_CTRL:       rd_mux = {26'h0, ctrl_r};
        `SRXE_IDX_STATUS:     rd_mux = {26'h0, fr_r == FR_BODY, resp_valid, rxd_full_r, ind_r};
        `SRXE_IDX_RX_DATA:    rd_mux = {24'h0, rxd_r};
        `SRXE_IDX_IRQ_STATUS: rd_mux = {27'h0, irq_st_r};
        `SRXE_IDX_IRQ_MASK:   rd_mux = {27'h0, irq_mask_r};
        // error-clear word is write-only and reads as zero
        default:              rd_mux = 32'h0000_0000;
      endcase
    end
  end

  always_comb begin
    ack_nxt   = (avs_read | avs_write) & ~ack_r;
    rdata_nxt = avs_readdata;
    if (avs_read & ~ack_r) begin
      rdata_nxt = rd_mux;
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      ack_r        <= 1'b0;
      avs_readdata <= 32'h0000_0000;
    end else begin
      ack_r        <= ack_nxt;
      avs_readdata <= rdata_nxt;
    end
  end

  // a pop only counts if the byte it removes was the one loaded into readdata;
  // a byte landing during the wait cycle stays held for the next read
  assign rd_pop = rd_go & (idx == `SRXE_IDX_RX_DATA) & pop_arm_r;

  always_comb begin
    pop_arm_nxt = 1'b0;
    if (avs_read & ~ack_r & aligned & (idx == `SRXE_IDX_RX_DATA)) begin
      pop_arm_nxt = rxd_full_r;
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      pop_arm_r <= 1'b0;
    end else begin
      pop_arm_r <= pop_arm_nxt;
    end
  end

  // frame handling
  always_comb begin
    fr_nxt     = fr_r;
    sum_nxt    = sum_r;
    prev_nxt   = prev_r;
    len_nxt    = len_r;
    frame_ok   = 1'b0;
    sum_fail   = 1'b0;
    proto_fail = 1'b0;
    overrun    = 1'b0;
    send_nak   = 1'b0;
    send_ack   = 1'b0;
    rxd_nxt    = rxd_r;
    rxd_full_nxt = rxd_full_r;
    if (rd_pop) begin
      rxd_full_nxt = 1'b0;
    end
    if (rx_valid) begin
      if (ctrl_r.mode == SRXE_MODE_NO_PROTO) begin
        fr_nxt = FR_IDLE;
        if (!rx_bad) begin
          if (rxd_full_r && !rd_pop) begin
            // held byte unread: new byte lost, flagged as overrun
            overrun = 1'b1;
          end else begin
            rxd_nxt      = rx_evt.data;
            rxd_full_nxt = 1'b1;
          end
        end
      end else if (fr_r == FR_IDLE) begin
        // bytes outside a frame, bad or not, are never delivered
        if (!rx_bad && rx_evt.data == `SRXE_HEAD_BYTE) begin
          fr_nxt   = FR_BODY;
          sum_nxt  = 8'h00;
          prev_nxt = 8'h00;
          len_nxt  = 8'h00;
        end
      end else begin
        if (rx_bad) begin
          fr_nxt   = FR_IDLE;
          send_nak = (ctrl_r.mode == SRXE_MODE_BIDIR) | ctrl_r.resp_en;
        end else if (rx_evt.data == `SRXE_HEAD_BYTE) begin
          // a second head inside a frame is a protocol error
          fr_nxt     = FR_IDLE;
          proto_fail = 1'b1;
          send_nak   = (ctrl_r.mode == SRXE_MODE_BIDIR) | ctrl_r.resp_en;
        end else if (rx_evt.data == `SRXE_TERM_BYTE) begin
          fr_nxt = FR_IDLE;
          if (ctrl_r.sum_en && (len_r == 8'h00 || prev_r != sum_r)) begin
            sum_fail = 1'b1;
            send_nak = (ctrl_r.mode == SRXE_MODE_BIDIR) | ctrl_r.resp_en;
          end else begin
            frame_ok = 1'b1;
            send_ack = 1'b1;
          end
        end else if (len_r == MAX_LEN) begin
          // limit tested after the end byte, so a body of exactly MAX_FRAME bytes passes;
          // one byte more drops the frame as a protocol error
          fr_nxt     = FR_IDLE;
          proto_fail = 1'b1;
          send_nak   = (ctrl_r.mode == SRXE_MODE_BIDIR) | ctrl_r.resp_en;
        end else begin
          // sum covers every body byte except the last, which is the check byte
          sum_nxt  = (len_r == 8'h00) ? 8'h00 : 8'(sum_r + prev_r);
          prev_nxt = rx_evt.data;
          len_nxt  = len_r + 8'h01;
        end
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      fr_r       <= FR_IDLE;
      sum_r      <= 8'h00;
      prev_r     <= 8'h00;
      len_r      <= 8'h00;
      rxd_r      <= 8'h00;
      rxd_full_r <= 1'b0;
    end else begin
      fr_r       <= fr_nxt;
      sum_r      <= sum_nxt;
      prev_r     <= prev_nxt;
      len_r      <= len_nxt;
      rxd_r      <= rxd_nxt;
      rxd_full_r <= rxd_full_nxt;
    end
  end

  // response byte: one outstanding answer; a later one is dropped while it waits
  always_comb begin
    resp_valid_nxt = resp_valid;
    resp_data_nxt  = resp_data;
    if (resp_valid && resp_ready) begin
      resp_valid_nxt = 1'b0;
    end
    if (!resp_valid && (send_nak || send_ack)) begin
      resp_valid_nxt = 1'b1;
      resp_data_nxt  = send_nak ? `SRXE_NAK_BYTE : `SRXE_ACK_BYTE;
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      resp_valid <= 1'b0;
      resp_data  <= 8'h00;
    end else begin
      resp_valid <= resp_valid_nxt;
      resp_data  <= resp_data_nxt;
    end
  end

  // indicators: set wins over a clear in the same cycle
  assign ind_set[0] = (rx_valid & rx_evt.par_err) | sum_fail;
  assign ind_set[1] = proto_fail;
  assign ind_set[2] = (rx_valid & rx_evt.frm_err) | overrun;
  assign ind_clr[0] = wr_go & (idx == `SRXE_IDX_ERR_CLEAR) & avs_writedata[`SRXE_CLR_SUM_BIT];
  assign ind_clr[1] = wr_go & (idx == `SRXE_IDX_ERR_CLEAR) & avs_writedata[`SRXE_CLR_PROTO_BIT];
  assign ind_clr[2] = wr_go & (idx == `SRXE_IDX_ERR_CLEAR) & avs_writedata[`SRXE_CLR_OVR_BIT];

  always_comb begin
    ind_nxt = ind_r;
    for (int i = 0; i < 3; i++) begin
      if (ind_set[i]) begin
        ind_nxt[i] = 1'b1;
      end else if (ind_clr[i]) begin
        ind_nxt[i] = 1'b0;
      end
    end
  end

  // control, interrupt status and mask
  assign irq_ev = {frame_ok, rxd_full_nxt & ~rxd_full_r, ind_set};

  always_comb begin
    ctrl_nxt     = ctrl_r;
    irq_mask_nxt = irq_mask_r;
    irq_st_nxt   = irq_st_r;
    if (wr_go && idx == `SRXE_IDX_CTRL) begin
      ctrl_nxt = srxe_ctrl_s'(avs_writedata[5:0]);
    end
    if (wr_go && idx == `SRXE_IDX_IRQ_MASK) begin
      irq_mask_nxt = avs_writedata[`SRXE_IRQ_W-1:0];
    end
    if (wr_go && idx == `SRXE_IDX_IRQ_STATUS) begin
      irq_st_nxt = irq_st_r & ~avs_writedata[`SRXE_IRQ_W-1:0];
    end
    irq_st_nxt = irq_st_nxt | irq_ev;
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      ctrl_r     <= srxe_ctrl_s'(6'(`SRXE_CTRL_RESET));
      ind_r      <= 3'h0;
      irq_st_r   <= '0;
      irq_mask_r <= '0;
    end else begin
      ctrl_r     <= ctrl_nxt;
      ind_r      <= ind_nxt;
      irq_st_r   <= irq_st_nxt;
      irq_mask_r <= irq_mask_nxt;
    end
  end

  assign sum_error_indicator      = ind_r[0];
  assign protocol_error_indicator = ind_r[1];
  assign serial_overrun_indicator = ind_r[2];
  assign irq                      = |(irq_st_r & irq_mask_r);
endmodule

/* srxe_err_ctrl_props.sv */
// port assertions of the receive error block
// assumes a bind onto srxe_err_ctrl and a single clock domain
`timescale 1ns/1ps
module srxe_err_ctrl_props (
  input wire logic        core_clk,
  input wire logic        sys_rst,
  input wire logic [11:0] avs_address,
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0]  avs_byteenable,
  input wire logic        avs_waitrequest,
  input wire logic        resp_valid,
  input wire logic [7:0]  resp_data,
  input wire logic        resp_ready,
  input wire logic        sum_error_indicator,
  input wire logic        protocol_error_indicator,
  input wire logic        serial_overrun_indicator
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  logic [7:0] clr;
  // clear bits of a write taken on this edge
  assign clr = (avs_write && !avs_waitrequest && avs_address == 12'h408 && avs_byteenable[0])
    ? avs_writedata[7:0] : 8'h00;
  sum_clear_a: assert property (clr[5] |=> !sum_error_indicator)
    else $error("sum indicator not cleared");
  proto_clear_a: assert property (clr[6] |=> !protocol_error_indicator)
    else $error("protocol indicator not cleared");
  ovr_clear_a: assert property (clr[7] |=> !serial_overrun_indicator)
    else $error("overrun indicator not cleared");
  sum_hold_a: assert property (sum_error_indicator && !clr[5] |=> sum_error_indicator)
    else $error("sum indicator dropped");
  proto_hold_a: assert property (protocol_error_indicator && !clr[6] |=> protocol_error_indicator)
    else $error("protocol indicator dropped");
  ovr_hold_a: assert property (serial_overrun_indicator && !clr[7] |=> serial_overrun_indicator)
    else $error("overrun indicator dropped");
  resp_stand_a: assert property (resp_valid && !resp_ready |=> resp_valid && $stable(resp_data))
    else $error("response byte not held");
  resp_code_a: assert property ($rose(resp_valid) |-> resp_data == 8'h06 || resp_data == 8'h15)
    else $error("unknown response code");
  one_wait_a: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("wait state too long");
endmodule

bind srxe_err_ctrl srxe_err_ctrl_props chk (.core_clk(core_clk), .sys_rst(sys_rst),
  .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
  .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
  .avs_waitrequest(avs_waitrequest), .resp_valid(resp_valid), .resp_data(resp_data),
  .resp_ready(resp_ready), .sum_error_indicator(sum_error_indicator),
  .protocol_error_indicator(protocol_error_indicator),
  .serial_overrun_indicator(serial_overrun_indicator));

/* srxe_err_ctrl_tb.sv */
// self-checking bench of the receive error block
// assumes srxe_ext_host and the bound checker are compiled in the same run
`timescale 1ns/1ps
`include "srxe_defines.svh"
module srxe_err_ctrl_tb;
  import srxe_pkg::*;
  localparam int          BC     = 16;
  localparam logic [11:0] A_CTRL = {`SRXE_IDX_CTRL, 2'b00};
  localparam logic [11:0] A_STAT = {`SRXE_IDX_STATUS, 2'b00};
  localparam logic [11:0] A_CLR  = {`SRXE_IDX_ERR_CLEAR, 2'b00};
  localparam logic [11:0] A_RXD  = {`SRXE_IDX_RX_DATA, 2'b00};
  localparam logic [11:0] A_IST  = {`SRXE_IDX_IRQ_STATUS, 2'b00};
  localparam logic [11:0] A_IMSK = {`SRXE_IDX_IRQ_MASK, 2'b00};
  logic        core_clk, sys_rst, avs_read, avs_write, avs_waitrequest;
  logic        rx_pin, resp_valid, resp_ready, irq, sum_i, proto_i, ovr_i;
  logic [11:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata, rd_q;
  logic [3:0]  avs_byteenable;
  logic [7:0]  resp_data;
  srxe_ctrl_s  ctl;
  int          miscompares, checks, cycles;

  srxe_err_ctrl #(.BIT_CYCLES(BC), .MAX_FRAME(4)) uut (.core_clk(core_clk),
    .sys_rst(sys_rst), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .rx_pin(rx_pin),
    .resp_valid(resp_valid), .resp_data(resp_data), .resp_ready(resp_ready),
    .sum_error_indicator(sum_i), .protocol_error_indicator(proto_i),
    .serial_overrun_indicator(ovr_i), .irq(irq));
  srxe_ext_host #(.BIT_CYCLES(BC)) host (.core_clk(core_clk), .rx_pin(rx_pin),
    .resp_valid(resp_valid), .resp_data(resp_data), .resp_ready(resp_ready));

  always #50 core_clk = ~core_clk;
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 60000) begin
      miscompares++;
      stop_test();
    end
  end

  task automatic stop_test;
    if (miscompares == 0 && checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic bus(input bit wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge core_clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= !wr;
    do @(posedge core_clk); while (avs_waitrequest !== 1'b0);
    rd_q = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask
  task automatic rdchk(input logic [11:0] a, input logic [31:0] m, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(rd_q & m, e);
  endtask
  task automatic inds(input logic [2:0] e);
    @(negedge core_clk);
    chk({29'h0, ovr_i, proto_i, sum_i}, {29'h0, e});
  endtask
  task automatic irqchk(input logic e);
    @(negedge core_clk);
    chk({31'h0, irq}, {31'h0, e});
  endtask
  task automatic clear_ind(input logic [2:0] i);
    bus(1'b1, A_CLR, {24'h0, ~{i, 5'h00} & 8'hE0});
    inds(i);
    bus(1'b1, A_CLR, {24'h0, i, 5'h00});
    inds(3'b000);
  endtask
  // bit 8 says a byte came; a byte where none is due mismatches
  task automatic rsp(input bit present, input logic [7:0] e);
    logic [8:0] got;
    got = 9'h000;
    for (int n = 0; n < 300 && host.resp_q.size() == 0; n++) @(posedge core_clk);
    if (host.resp_q.size() != 0) got = {1'b1, host.resp_q.pop_front()};
    chk({23'h0, got}, {23'h0, present, present ? e : 8'h00});
  endtask
  // kinds: 0 good, 1 bad parity on end byte, 2 wrong sum, 3 bad byte before head
  task automatic frm(input int k);
    logic [7:0] b;
    b = 8'($urandom()) | 8'h80;
    if (k != 3) host.send(8'h05, 1'b0, 1'b0);
    if (k != 3) host.send(b, 1'b0, 1'b0);
    host.send(k == 2 ? b ^ 8'h01 : b, k == 3, 1'b0);
    if (k != 3) host.send(8'h0D, k == 1, 1'b0);
  endtask
  function automatic logic [8:0] exp_resp(input srxe_mode_e m, input logic ren, input int k);
    if (k == 0) return {1'b1, 8'h06};
    if (k == 3) return 9'h000;
    return {(m == SRXE_MODE_BIDIR) || ren, 8'h15};
  endfunction
  function automatic logic [2:0] exp_ind(input int k);
    return (k == 0) ? 3'b000 : 3'b001;
  endfunction

  initial begin
    logic [8:0] e;
    logic [7:0] b;
    void'($urandom(1171));
    core_clk = 1'b0;
    sys_rst = 1'b1;
    {avs_read, avs_write, avs_address, avs_writedata} = '0;
    avs_byteenable = 4'hF;
    repeat (16) @(posedge core_clk);
    sys_rst <= 1'b0;
    inds(3'b000);
    rdchk(A_CTRL, 32'hFF, 32'h0);
    rdchk(12'h7F0, 32'hFFFF_FFFF, 32'h0);
    rdchk(A_CLR, 32'hFFFF_FFFF, 32'h0);
    for (int m = 0; m < 3; m += 2) begin
      for (int r = 0; r < 2; r++) begin
        for (int k = 0; k < 4; k++) begin
          ctl = '{1'b0, 1'b1, r[0], 1'b1, srxe_mode_e'(m)};
          bus(1'b1, A_CTRL, {26'h0, ctl});
          frm(k);
          e = exp_resp(ctl.mode, ctl.resp_en, k);
          rsp(e[8], e[7:0]);
          inds(exp_ind(k));
          clear_ind(exp_ind(k));
        end
      end
    end
    host.send(8'h05, 1'b0, 1'b0);
    host.send(8'h05, 1'b0, 1'b0);
    rsp(1'b1, 8'h15);
    inds(3'b010);
    repeat (300) @(posedge core_clk);
    host.resp_q.delete();
    clear_ind(3'b010);
    ctl = '{1'b0, 1'b1, 1'b0, 1'b0, SRXE_MODE_NO_PROTO};
    bus(1'b1, A_CTRL, {26'h0, ctl});
    bus(1'b1, A_IST, 32'h1F);
    bus(1'b1, A_IMSK, 32'h01);
    b = 8'($urandom());
    host.send(b, 1'b0, 1'b0);
    host.send(~b, 1'b1, 1'b0);
    rdchk(A_RXD, 32'hFF, {24'h0, b});
    rdchk(A_STAT, 32'h0F, 32'h01);
    irqchk(1'b1);
    bus(1'b1, A_IMSK, 32'h00);
    irqchk(1'b0);
    bus(1'b1, A_IMSK, 32'h01);
    irqchk(1'b1);
    bus(1'b1, A_IST, 32'h01);
    irqchk(1'b0);
    rdchk(A_IST, 32'h01, 32'h0);
    clear_ind(3'b001);
    host.send(b, 1'b0, 1'b0);
    host.send(~b, 1'b0, 1'b0);
    inds(3'b100);
    rdchk(A_RXD, 32'hFF, {24'h0, b});
    clear_ind(3'b100);
    host.send(b, 1'b0, 1'b1);
    inds(3'b100);
    clear_ind(3'b100);
    stop_test();
  end
endmodule

/* srxe_ext_host.sv */
// external computer: sends bytes on the serial line, takes response bytes
// assumes the bench gives it the design's bit length in clocks
`timescale 1ns/1ps
module srxe_ext_host #(
  parameter int BIT_CYCLES = 16
) (
  input  wire logic       core_clk,
  output logic            rx_pin,
  input  wire logic       resp_valid,
  input  wire logic [7:0] resp_data,
  output logic            resp_ready
);
  logic [7:0] resp_q[$];
  initial begin
    rx_pin = 1'b1;
    resp_ready = 1'b0;
  end
  // random stalls so the response byte must stand
  always @(posedge core_clk) begin
    if (resp_valid && resp_ready) resp_q.push_back(resp_data);
    resp_ready <= ($urandom_range(3) != 0);
  end
  // even parity; idle gap lets the receiver resync after a bad stop bit
  task automatic send(input logic [7:0] d, input bit bad_par, input bit bad_stop);
    logic [10:0] f;
    f = {!bad_stop, (^d) ^ bad_par, d, 1'b0};
    for (int i = 0; i < 11; i++) begin
      @(posedge core_clk);
      rx_pin <= f[i];
      repeat (BIT_CYCLES - 1) @(posedge core_clk);
    end
    @(posedge core_clk);
    rx_pin <= 1'b1;
    repeat (2 * BIT_CYCLES) @(posedge core_clk);
  endtask
endmodule

/* srxe_pkg.sv */
// types shared by the receive error block
// assumes srxe_defines.svh for numeric constants
package srxe_pkg;
  `include "srxe_defines.svh"

  typedef enum logic [1:0] {
    SRXE_MODE_DEDICATED,
    SRXE_MODE_NO_PROTO,
    SRXE_MODE_BIDIR,
    SRXE_MODE_SPARE
  } srxe_mode_e;

  typedef struct packed {
    logic [7:0] data;
    logic       par_err;
    logic       frm_err;
  } srxe_rx_evt_s;

  typedef struct packed {
    logic       par_odd;
    logic       par_en;
    logic       resp_en;
    logic       sum_en;
    srxe_mode_e mode;
  } srxe_ctrl_s;
endpackage
